// [ckg_top.sv]
// Purpose: Clock generation unit with strap-selected ratios and gating
// Assumes: ref_clk is the fast synthesis reference of the main PLL
// Notes: Output clocks are numerically synthesised square waves on ref_clk;
//   edges carry up to one ref_clk period of jitter, so ref_clk must be many
//   times faster than the fastest generated clock.
`timescale 1ns/1ps
`include "ckg_params.svh"
module ckg_top #(
  parameter int PER_W = 16,
  parameter int DATA_W = 32
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic master_in_clock,
  input wire ckg_pkg::ckg_strap_s strap_pins,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output ckg_pkg::ckg_clk_s int_clocks,
  output logic ext_bus_clock_out,
  output logic ext_bus_clock_oe,
  output logic [3:0] sdram_clock_out,
  input wire logic sdram_feedback_clock,
  input wire logic [DATA_W-1:0] sdram_read_data,
  output logic [DATA_W-1:0] sdram_latched_data,
  output logic sdram_latched_valid,
  output logic pll_locked
);
  import ckg_pkg::*;

  // Pin synchronisers: stage 1 feeds only stage 2
  logic [2:0] mclk_sync_q;
  ckg_strap_s strap_s1_q, strap_s2_q;
  logic [2:0] fb_sync_q;
  logic [DATA_W-1:0] rd_s1_q, rd_s2_q, rd_s3_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mclk_sync_q <= '0;
    end else if (ce) begin
      mclk_sync_q <= {mclk_sync_q[1:0], master_in_clock};
    end
  end

  // Strap stages keep sampling during reset, so the pin levels are
  // already in stage 2 when reset lifts; a reset here would capture zero
  always_ff @(posedge ref_clk) begin
    if (ce) begin
      strap_s1_q <= strap_pins;
      strap_s2_q <= strap_s1_q;
    end
  end

  // Strap capture once
  // Taken on the first enabled edge after release, then frozen
  ckg_strap_s strap_q;
  logic strap_done_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      strap_q <= '0;
      strap_done_q <= 1'b0;
    end else if (ce && !strap_done_q) begin
      strap_q <= strap_s2_q;
      strap_done_q <= 1'b1;
    end
  end

  // Core ratio table
  // LHH is printed twice; the x10 entry is taken as LHL
  function automatic ckg_halves_t core_halves(input logic [2:0] code);
    ckg_halves_t h;
    h = `CKG_CORE_LLL;
    unique case (code)
      3'b111: h = `CKG_CORE_HHH;
      3'b110: h = `CKG_CORE_HHL;
      3'b101: h = `CKG_CORE_HLH;
      3'b100: h = `CKG_CORE_HLL;
      3'b011: h = `CKG_CORE_LHH;
      3'b010: h = `CKG_CORE_LHL;
      3'b001: h = `CKG_CORE_LLH;
      3'b000: h = `CKG_CORE_LLL;
    endcase
    return h;
  endfunction : core_halves

  function automatic logic [2:0] ext_div(input logic [1:0] code);
    logic [2:0] d;
    d = `CKG_EXT_DIV_LL;
    unique case (code)
      2'b00: d = `CKG_EXT_DIV_LL;
      2'b01: d = `CKG_EXT_DIV_LH;
      2'b10: d = `CKG_EXT_DIV_HL;
      2'b11: d = `CKG_EXT_DIV_HH;
    endcase
    return d;
  endfunction : ext_div

  ckg_halves_t core_inc, bus_inc;
  logic [2:0] ext_divisor;
  assign core_inc = core_halves(strap_q.core_ratio_select);
  assign bus_inc = strap_q.core_ratio_select[2] ? `CKG_BUS_X1 : `CKG_BUS_X4;
  assign ext_divisor = ext_div(strap_q.ext_bus_clock_ratio);

  // Master period measurement: the frequency-lock part of the main PLL
  logic mclk_rise;
  logic [PER_W-1:0] cnt_q, period_q, prev_period_q;
  logic lock_q;
  assign mclk_rise = mclk_sync_q[1] & ~mclk_sync_q[2];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      period_q <= '0;
      prev_period_q <= '0;
      lock_q <= 1'b0;
    end else if (ce) begin
      if (mclk_rise) begin
        cnt_q <= '0;
        period_q <= cnt_q + 1'b1;
        prev_period_q <= period_q;
        // Lock needs two equal periods, long enough for a x16 core
        lock_q <= (cnt_q + 1'b1 == period_q) &&
                  (period_q >= `CKG_MIN_MASTER_PERIOD) && strap_done_q;
      end else if (cnt_q != {PER_W{1'b1}}) begin
        cnt_q <= cnt_q + 1'b1;
      end else begin
        lock_q <= 1'b0;  // Master clock lost
      end
    end
  end

  // Phase accumulator step: adds inc, wraps at period, flags the wrap
  function automatic logic [PER_W:0] nco_step(input logic [PER_W-1:0] acc,
                                              input ckg_halves_t inc,
                                              input logic [PER_W-1:0] per);
    logic [PER_W:0] sum;
    sum = {1'b0, acc} + {{(PER_W-5){1'b0}}, inc};
    if (sum >= {1'b0, per}) begin
      sum = sum - {1'b0, per};
      return {1'b1, sum[PER_W-1:0]};
    end
    return {1'b0, sum[PER_W-1:0]};
  endfunction : nco_step

  logic [PER_W:0] core_step, bus_step;
  logic [PER_W-1:0] core_acc_q, bus_acc_q;
  logic core_q, bus_q;
  logic bus_evt;
  assign core_step = nco_step(core_acc_q, core_inc, period_q);
  assign bus_step = nco_step(bus_acc_q, bus_inc, period_q);
  assign bus_evt = lock_q & bus_step[PER_W];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      core_acc_q <= '0;
      core_q <= 1'b0;
    end else if (ce) begin
      if (!lock_q) begin
        core_acc_q <= '0;
        core_q <= 1'b0;
      end else begin
        core_acc_q <= core_step[PER_W-1:0];
        if (core_step[PER_W]) begin
          core_q <= ~core_q;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bus_acc_q <= '0;
      bus_q <= 1'b0;
    end else if (ce) begin
      if (!lock_q) begin
        bus_acc_q <= '0;
        bus_q <= 1'b0;
      end else begin
        bus_acc_q <= bus_step[PER_W-1:0];
        if (bus_step[PER_W]) begin
          bus_q <= ~bus_q;
        end
      end
    end
  end

  logic peri_clk;
  ckg_clk_div #(.CNT_W(3)) u_peri_div (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .run(lock_q),
    .toggle_evt(bus_evt & ~bus_q),
    .div(`CKG_PERI_DIV / 3'd2),
    .clk_out(peri_clk)
  );

  logic ext_clk;
  ckg_clk_div #(.CNT_W(3)) u_ext_div (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .run(lock_q),
    .toggle_evt(bus_evt),
    .div(ext_divisor),
    .clk_out(ext_clk)
  );

  // Register file state
  logic ext_en_q;
  logic [3:0] sd_en_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [DATA_W-1:0] fb_data_q;
  logic fb_valid_q;

  // Bus handshake: one wait cycle, then the answer for one cycle
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata = rdata_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
    end else if (ce) begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  // Read mux; unmapped offsets read as zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= '0;
    end else if (ce && avs_read && !ack_q) begin
      rdata_q <= '0;
      unique case (avs_address)
        `CKG_PIN_CONFIG_OFS: begin
          rdata_q[`CKG_PIN_CONFIG_REGISTER_EXT_EN_BIT] <= ext_en_q;
          rdata_q[`CKG_PIN_CONFIG_REGISTER_SD_EN_LSB +: 4] <= sd_en_q;
        end
        `CKG_CHIP_CONFIG_OFS: begin
          rdata_q[`CKG_CHIP_CONFIG_REGISTER_CORE_LSB +: 3] <= strap_q.core_ratio_select;
          rdata_q[`CKG_CHIP_CONFIG_REGISTER_EXT_LSB +: 2] <= strap_q.ext_bus_clock_ratio;
          rdata_q[`CKG_CHIP_CONFIG_REGISTER_LOCK_BIT] <= lock_q;
        end
        `CKG_FEEDBACK_DATA_OFS: rdata_q[DATA_W-1:0] <= fb_data_q;
        default: rdata_q <= '0;
      endcase
    end
  end

  // Enable bits written
  // Writes land on the acknowledge edge; byte 0 holds every field
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ext_en_q <= `CKG_PIN_CONFIG_REGISTER_EXT_EN_RST;
      sd_en_q <= `CKG_PIN_CONFIG_REGISTER_SD_EN_RST;
    end else if (ce && avs_write && ack_q && avs_byteenable[0] &&
                 avs_address == `CKG_PIN_CONFIG_OFS) begin
      ext_en_q <= avs_writedata[`CKG_PIN_CONFIG_REGISTER_EXT_EN_BIT];
      sd_en_q <= avs_writedata[`CKG_PIN_CONFIG_REGISTER_SD_EN_LSB +: 4];
    end
  end

  // Per-bit SDRAM gating
  // Enables are adopted only while the bus clock is low so no pulse is cut
  logic [3:0] sd_gate_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sd_gate_q <= '0;
    end else if (ce && !bus_q && !bus_evt) begin
      sd_gate_q <= sd_en_q;
    end
  end

  logic [3:0] sd_out_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sd_out_q <= '0;
    end else if (ce) begin
      sd_out_q <= {4{bus_q}} & sd_gate_q;
    end
  end
  assign sdram_clock_out = sd_out_q;

  // External clock drive enable
  // The pad stops driving when the enable is clear
  logic ext_out_q, ext_oe_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ext_out_q <= 1'b0;
      ext_oe_q <= 1'b0;
    end else if (ce) begin
      ext_out_q <= ext_clk & ext_en_q;
      ext_oe_q <= ext_en_q;
    end
  end
  assign ext_bus_clock_out = ext_out_q;
  assign ext_bus_clock_oe = ext_oe_q;

  // Internal clocks registered to align with the pad outputs
  ckg_clk_s clk_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      clk_q <= '0;
    end else if (ce) begin
      clk_q.core_clock <= core_q;
      clk_q.system_bus_clock <= bus_q;
      clk_q.peripheral_bus_clock <= peri_clk;
    end
  end
  assign int_clocks = clk_q;
  assign pll_locked = lock_q;

  // Feedback clock and read data synchronisers
  // Data gets one extra stage so it lines up with the edge detector
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fb_sync_q <= '0;
      rd_s1_q <= '0;
      rd_s2_q <= '0;
      rd_s3_q <= '0;
    end else if (ce) begin
      fb_sync_q <= {fb_sync_q[1:0], sdram_feedback_clock};
      rd_s1_q <= sdram_read_data;
      rd_s2_q <= rd_s1_q;
      rd_s3_q <= rd_s2_q;
    end
  end

  // Latch on feedback edge
  // Data are taken as they stood at the rising feedback edge
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fb_data_q <= '0;
      fb_valid_q <= 1'b0;
    end else if (ce) begin
      fb_valid_q <= fb_sync_q[1] & ~fb_sync_q[2];
      if (fb_sync_q[1] & ~fb_sync_q[2]) begin
        fb_data_q <= rd_s3_q;
      end
    end
  end
  assign sdram_latched_data = fb_data_q;
  assign sdram_latched_valid = fb_valid_q;

endmodule : ckg_top

// [ckg_params.svh]
// Purpose: Constants of the clock generation unit: offsets, fields, resets
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one word per register
// Notes: Ratios are kept in half units so that the x2.5 step stays integral
`ifndef CKG_PARAMS_SVH
`define CKG_PARAMS_SVH

// Reference clock rate, for information in derived counts
`define CKG_REF_CLK_MHZ 50

// Register byte offsets
`define CKG_PIN_CONFIG_OFS 4'h0
`define CKG_CHIP_CONFIG_OFS 4'h4
`define CKG_FEEDBACK_DATA_OFS 4'h8

// Pin configuration fields
`define CKG_PIN_CONFIG_REGISTER_EXT_EN_BIT 0
`define CKG_PIN_CONFIG_REGISTER_SD_EN_LSB 4
`define CKG_PIN_CONFIG_REGISTER_EXT_EN_RST 1'h1
`define CKG_PIN_CONFIG_REGISTER_SD_EN_RST 4'hf

// Chip configuration fields (read only)
`define CKG_CHIP_CONFIG_REGISTER_CORE_LSB 0
`define CKG_CHIP_CONFIG_REGISTER_EXT_LSB 3
`define CKG_CHIP_CONFIG_REGISTER_LOCK_BIT 8

// Core ratios in half units, indexed by strap code
`define CKG_CORE_HHH 6'd4
`define CKG_CORE_HHL 6'd5
`define CKG_CORE_HLH 6'd6
`define CKG_CORE_HLL 6'd8
`define CKG_CORE_LHH 6'd16
`define CKG_CORE_LHL 6'd20
`define CKG_CORE_LLH 6'd24
`define CKG_CORE_LLL 6'd32

// Bus ratios in half units, by strap bit 2
`define CKG_BUS_X4 6'd8
`define CKG_BUS_X1 6'd2

// External bus clock divisors, by strap code
`define CKG_EXT_DIV_LL 3'd4
`define CKG_EXT_DIV_LH 3'd3
`define CKG_EXT_DIV_HL 3'd2
`define CKG_EXT_DIV_HH 3'd1

// Peripheral bus divisor from the bus clock
`define CKG_PERI_DIV 3'd2

// Least master period, in reference cycles, that the synthesiser accepts
`define CKG_MIN_MASTER_PERIOD 16'd33

`endif

// [ckg_pkg.sv]
// Purpose: Types shared by the clock generation unit
// Assumes: Constants live in ckg_params.svh
// Notes: Packed structs carry signals that travel together
package ckg_pkg;

  // Boot strap levels as sampled from the address pins
  typedef struct packed {
    logic [1:0] ext_bus_clock_ratio;
    logic [2:0] core_ratio_select;
  } ckg_strap_s;

  // Internal clocks handed to the rest of the chip
  typedef struct packed {
    logic core_clock;
    logic system_bus_clock;
    logic peripheral_bus_clock;
  } ckg_clk_s;

  typedef logic [5:0] ckg_halves_t;

endpackage : ckg_pkg

// [ckg_clk_div.sv]
// Purpose: Divides a stream of toggle events into a slower square wave
// Assumes: One event per half period of the source clock
// Notes: Counting half periods gives a 50 percent duty for odd divisors
`timescale 1ns/1ps
module ckg_clk_div #(
  parameter int CNT_W = 3
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic run,
  input wire logic toggle_evt,
  input wire logic [CNT_W-1:0] div,
  output logic clk_out
);

  logic [CNT_W-1:0] cnt_q;
  logic out_q;

  // Toggle once every div source half periods
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        cnt_q <= '0;
        out_q <= 1'b0;
      end else if (toggle_evt) begin
        if (cnt_q + 1'b1 >= div) begin
          cnt_q <= '0;
          out_q <= ~out_q;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  assign clk_out = out_q;

endmodule : ckg_clk_div

// [ckg_top_asserts.sv]
// Purpose: Port-level checks of the clock generation unit
// Assumes: One ref_clk domain; checks pause while ce is low
// Notes: Output clocks jitter by one ref_clk, so bounds allow a cycle
`timescale 1ns/1ps
module ckg_top_asserts #(
  parameter int DATA_W = 32
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire ckg_pkg::ckg_clk_s int_clocks,
  input wire logic ext_bus_clock_out,
  input wire logic ext_bus_clock_oe,
  input wire logic [3:0] sdram_clock_out,
  input wire logic sdram_feedback_clock,
  input wire logic [DATA_W-1:0] sdram_read_data,
  input wire logic [DATA_W-1:0] sdram_latched_data,
  input wire logic sdram_latched_valid,
  input wire logic pll_locked
);
  import ckg_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn || !ce);

  // Bus answers after exactly one wait cycle, and only once
  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait not one cycle");
  property p_ack_once;
    (avs_read || avs_write) && !avs_waitrequest
      |=> avs_waitrequest || !(avs_read || avs_write);
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("double answer");
  property p_oe_off;
    !ext_bus_clock_oe |-> !ext_bus_clock_out;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("ext clock undriven");
  property p_quiet;
    !pll_locked |-> int_clocks == 3'h0 && sdram_clock_out == 4'h0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("clock before lock");
  property p_peri_half;
    $rose(int_clocks.system_bus_clock)
      |-> ##[0:1] $changed(int_clocks.peripheral_bus_clock);
  endproperty
  a_peri_half: assert property (p_peri_half) else $error("peri no toggle");
  // SDRAM clocks and the bus clock leave through registers of equal depth
  property p_sd_follow;
    |(sdram_clock_out & ~$past(sdram_clock_out))
      |-> $rose(int_clocks.system_bus_clock);
  endproperty
  a_sd_follow: assert property (p_sd_follow) else $error("sdram rise");
  property p_fb_valid;
    $rose(sdram_feedback_clock) |-> ##[2:4] sdram_latched_valid;
  endproperty
  a_fb_valid: assert property (p_fb_valid) else $error("no latch");
  property p_valid_pulse;
    sdram_latched_valid |=> !sdram_latched_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("long pulse");
  property p_valid_data;
    sdram_latched_valid |-> sdram_latched_data == $past(sdram_read_data, 3);
  endproperty
  a_valid_data: assert property (p_valid_data) else $error("bad data");

  // Main scenarios reached
  c_latch: cover property (sdram_latched_valid);
  c_ext_off: cover property (pll_locked && !ext_bus_clock_oe);
  c_read: cover property (avs_read && !avs_waitrequest);
endmodule : ckg_top_asserts

bind ckg_top ckg_top_asserts #(.DATA_W(DATA_W)) u_chk (
  .ref_clk(ref_clk), .rstn(rstn), .ce(ce), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .int_clocks(int_clocks), .ext_bus_clock_out(ext_bus_clock_out),
  .ext_bus_clock_oe(ext_bus_clock_oe), .sdram_clock_out(sdram_clock_out),
  .sdram_feedback_clock(sdram_feedback_clock),
  .sdram_read_data(sdram_read_data),
  .sdram_latched_data(sdram_latched_data),
  .sdram_latched_valid(sdram_latched_valid), .pll_locked(pll_locked));

// [ckg_sdram_model.sv]
// Purpose: SDRAM side: clock loopback and read data
// Assumes: Board trace from the first SDRAM clock output
// Notes: Data change on the falling edge, far from the latching edge
`timescale 1ns/1ps
module ckg_sdram_model #(
  parameter int DATA_W = 32
) (
  input wire logic sdram_clock,
  output logic sdram_feedback_clock,
  output logic [DATA_W-1:0] sdram_read_data
);
  assign #3 sdram_feedback_clock = sdram_clock;
  // New word each clock; stands still while the clock is gated
  initial sdram_read_data = DATA_W'(32'h5a5a_0000);
  always @(negedge sdram_feedback_clock) begin
    sdram_read_data <= sdram_read_data + DATA_W'(32'h0001_0003);
  end
endmodule : ckg_sdram_model

// [ckg_top_bench.sv]
// Purpose: Self-checking bench for the clock generation unit
// Assumes: Master clock of 128 ref_clk cycles, ce held high except one 128-cycle pause in gating
// Notes: Edge counts allow one edge of slack for window phase
`timescale 1ns/1ps
module ckg_top_bench;
  import ckg_pkg::*;
  logic ref_clk = 1'b0, rstn = 1'b0, ce = 1'b1, mclk = 1'b0;
  logic [5:0] mdiv = 6'h00;
  ckg_strap_s strap_pins = 5'h00;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
  logic avs_waitrequest, ext_bus_clock_out, ext_bus_clock_oe, pll_locked;
  ckg_clk_s int_clocks;
  logic [3:0] sdram_clock_out;
  logic sdram_feedback_clock, sdram_latched_valid, counting = 1'b0;
  logic [31:0] sdram_read_data, sdram_latched_data, fb_word;
  logic [8:0] prv = 9'h000, cur;
  int n[9];
  int mismatches = 0, checked = 0, cyc = 0;

  always #10 ref_clk = ~ref_clk;
  // Master clock, 64 ref cycles per half
  always @(posedge ref_clk) begin
    mdiv <= mdiv + 6'h01;
    if (mdiv == 6'h3f) mclk <= ~mclk;
  end

  ckg_top DUT (.ref_clk(ref_clk), .rstn(rstn), .ce(ce),
    .master_in_clock(mclk), .strap_pins(strap_pins),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .int_clocks(int_clocks), .ext_bus_clock_out(ext_bus_clock_out),
    .ext_bus_clock_oe(ext_bus_clock_oe), .sdram_clock_out(sdram_clock_out),
    .sdram_feedback_clock(sdram_feedback_clock),
    .sdram_read_data(sdram_read_data),
    .sdram_latched_data(sdram_latched_data),
    .sdram_latched_valid(sdram_latched_valid), .pll_locked(pll_locked));
  ckg_sdram_model u_sdram (.sdram_clock(sdram_clock_out[0]),
    .sdram_feedback_clock(sdram_feedback_clock),
    .sdram_read_data(sdram_read_data));

  // Count rising edges of every clock output and of the latch valid inside the window
  assign cur = {sdram_latched_valid, sdram_clock_out, ext_bus_clock_out,
    int_clocks};
  always @(posedge ref_clk) begin
    prv <= cur;
    if (counting) begin
      for (int k = 0; k < 9; k++) begin
        if (cur[k] === 1'b1 && prv[k] === 1'b0) n[k]++;
      end
    end
  end

  // Word on the pins at the feedback edge must reach the latch
  always @(posedge sdram_feedback_clock) fb_word <= sdram_read_data;
  always @(posedge ref_clk) begin
    if (sdram_latched_valid === 1'b1) begin
      check("latched data", sdram_latched_data, fb_word);
    end
  end

  // Cut a hang short
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      give_verdict;
    end
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic near(string what, int seen, int exp);
    check(what, 32'((seen >= exp - 1 && seen <= exp + 1) ? exp : seen),
      32'(exp));
  endtask : near

  // Hold the request until waitrequest is seen low at a rising edge
  // Only the bench timeout ends a wait that never completes
  task automatic bus_xfer(logic wr, logic [3:0] a, logic [31:0] d,
      output logic [31:0] q);
    @(posedge ref_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus_xfer

  task automatic do_reset(ckg_strap_s s);
    @(posedge ref_clk);
    rstn <= 1'b0;
    strap_pins <= s;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask : do_reset

  task automatic measure;
    for (int k = 0; k < 9; k++) n[k] = 0;
    @(posedge ref_clk);
    counting <= 1'b1;
    repeat (1024) @(posedge ref_clk);
    counting <= 1'b0;
  endtask : measure

  task automatic regs;
    logic [31:0] q;
    bus_xfer(1'b0, 4'h0, 32'h0000_0000, q);
    check("pin config reset", q, 32'h0000_00f1);
    bus_xfer(1'b1, 4'hc, 32'hffff_ffff, q);
    bus_xfer(1'b0, 4'hc, 32'h0000_0000, q);
    check("unmapped", q, 32'h0000_0000);
  endtask : regs

  // Every core and external code; straps flip after capture
  task automatic ratios;
    logic [31:0] q;
    int hv[8] = '{32, 24, 20, 16, 8, 6, 5, 4};
    int bx;
    for (int i = 0; i < 8; i++) begin
      do_reset(ckg_strap_s'({i[1:0], i[2:0]}));
      for (int w = 0; w < 2000 && pll_locked !== 1'b1; w++) begin
        @(posedge ref_clk);
      end
      check("locked", 32'(pll_locked), 32'h0000_0001);
      strap_pins <= ~strap_pins;
      bx = i[2] ? 8 : 32;
      measure;
      near("core edges", n[2], 4 * hv[i]);
      near("bus edges", n[1], bx);
      near("peri edges", n[0], bx / 2);
      near("ext edges", n[3], bx / (4 - i % 4));
      for (int k = 4; k < 8; k++) near("sdram edges", n[k], bx);
      near("latch pulses", n[8], bx);
      bus_xfer(1'b1, 4'h4, 32'hffff_ffff, q);
      bus_xfer(1'b0, 4'h4, 32'h0000_0000, q);
      check("chip config", q, {23'h0, 1'b1, 3'h0, i[1:0], i[2:0]});
    end
  endtask : ratios

  // Gating of the external and SDRAM clocks, bus clock x1
  task automatic gating;
    logic [31:0] q;
    ckg_clk_s clk0;
    bus_xfer(1'b1, 4'h0, 32'h0000_0050, q);
    bus_xfer(1'b0, 4'h0, 32'h0000_0000, q);
    check("pin config", q, 32'h0000_0050);
    repeat (64) @(posedge ref_clk);
    check("ext oe off", 32'(ext_bus_clock_oe), 32'h0000_0000);
    measure;
    check("ext edges off", 32'(n[3]), 32'h0000_0000);
    check("sdram1 edges", 32'(n[5]), 32'h0000_0000);
    check("sdram3 edges", 32'(n[7]), 32'h0000_0000);
    near("sdram0 edges", n[4], 8);
    near("sdram2 edges", n[6], 8);
    bus_xfer(1'b1, 4'h0, 32'h0000_0001, q);
    repeat (64) @(posedge ref_clk);
    check("ext oe on", 32'(ext_bus_clock_oe), 32'h0000_0001);
    // Freeze for one whole master period so the lock survives the pause
    ce <= 1'b0;
    @(posedge ref_clk);
    clk0 = int_clocks;
    repeat (80) @(posedge ref_clk);
    check("frozen clocks", {29'h0, int_clocks}, {29'h0, clk0});
    repeat (47) @(posedge ref_clk);
    ce <= 1'b1;
    repeat (300) @(posedge ref_clk);
    check("lock kept", 32'(pll_locked), 32'h0000_0001);
  endtask : gating

  task automatic give_verdict;
    if (mismatches == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    regs;
    ratios;
    gating;
    give_verdict;
  end
endmodule : ckg_top_bench
